// *** tsc_regs.svh ***
// register offsets, field positions, reset values and timing counts
`ifndef TSC_REGS_SVH
`define TSC_REGS_SVH
`define TSC_OFF_CTRL 4'h0
`define TSC_OFF_STAT 4'h4
`define TSC_OFF_FAIL 4'h8
`define TSC_CTRL_RESET 8'h38
`define TSC_CTRL_PLL_BIT 7
`define TSC_CTRL_FREQ_HI 6
`define TSC_CTRL_FREQ_LO 3
`define TSC_STAT_SOSC_BIT 7
`define TSC_STAT_PLL_RDY_BIT 6
`define TSC_STAT_TMR_DONE_BIT 5
`define TSC_STAT_HFR_BIT 4
`define TSC_STAT_HFL_BIT 3
`define TSC_STAT_MFR_BIT 2
`define TSC_STAT_LFR_BIT 1
`define TSC_STAT_HFS_BIT 0
`define TSC_FAIL_FLAG_BIT 0
`define TSC_FAIL_IE_BIT 1
`define TSC_STARTUP_COUNT 1024
`define TSC_SAMPLE_DIV 64
`define TSC_MODE_LOWPWR 3'h0
`define TSC_MODE_STD 3'h1
`define TSC_MODE_FAST 3'h2
`define TSC_MODE_INTERNAL 3'h4
`define TSC_SCS_CFG 2'h0
`define TSC_SCS_SEC 2'h1
`define TSC_RESP_OKAY 2'h0
`define TSC_RESP_SLVERR 2'h2
`endif

// *** tsc_pkg.sv ***
// types for the two-speed start-up and fail-safe clock block
package tsc_pkg;
  typedef enum logic [2:0] {
    TSC_ST_IDLE = 3'b000,
    TSC_ST_COUNT = 3'b001,
    TSC_ST_WAIT_INT = 3'b010,
    TSC_ST_HOLD = 3'b011,
    TSC_ST_EXT = 3'b100
  } tsc_state_e;

  typedef enum logic [1:0] {
    TSC_SRC_INT = 2'b00,
    TSC_SRC_EXT = 2'b01,
    TSC_SRC_SEC = 2'b10
  } tsc_src_e;

  typedef struct packed {
    logic [2:0] osc_mode_config;
    logic two_speed_config_enable;
    logic fail_monitor_enable;
    logic cfg_pll_enable;
  } tsc_cfg_s;

  typedef struct packed {
    logic sec_osc_enable;
    logic sec_osc_raw_ready;
    logic pll_ready_status;
    logic high_osc_ready;
    logic high_osc_locked;
    logic high_osc_stable;
    logic mid_osc_ready;
    logic low_osc_ready;
  } tsc_osc_stat_s;

  typedef struct packed {
    logic awvalid;
    logic [3:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [3:0] araddr;
    logic rready;
  } tsc_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } tsc_axi_rsp_s;
endpackage : tsc_pkg

// *** tsc_clock_ctrl.sv ***
// two-speed start-up, fail-safe monitor and oscillator registers
//
// Local design decisions: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "tsc_regs.svh"

//Contract
// R01: crystal modes wait 1024 oscillations before use
// R02: non-crystal modes disable two-speed start-up
// R03: count done while awake sets status, switches
// R04: sleep aborts count, status stays clear
// R05: two-speed needs enable, select 00, crystal
// R06: start-up after reset/powerup timer and wake
// R07: count, internal fall, status, external fall
// R08: status one on external, zero on internal
// R09: monitor enable covers all, forces two-speed
// R10: sample clock is low osc divided 64
// R11: latch set by external, cleared by sample
// R12: failure selects internal, sets fail flag
// R13: stay internal until firmware switches back
// R14: reset, sleep, select write clear fail-safe
// R15: select change restarts timer, clears on switch
// R16: flag set again while failure persists
// R17: external clock modes: monitor active immediately
// R18: config pll overrides software pll bit
// R19: frequency select resets to 0111
// R20: select 00 config, 01 secondary, 1x internal
// R21: secondary ready reads one when disabled
// R22: locked, stable and ready bits read back
// R23: reset clears system clock select
// R24: automatic switches leave select untouched
// R25: failure indication synchronised before use
module tsc_clock_ctrl #(
  parameter int STARTUP_COUNT = `TSC_STARTUP_COUNT,
  parameter int SAMPLE_DIV = `TSC_SAMPLE_DIV
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire tsc_pkg::tsc_axi_req_s axi_req,
  output tsc_pkg::tsc_axi_rsp_s axi_rsp,
  input wire tsc_pkg::tsc_cfg_s cfg,
  input wire tsc_pkg::tsc_osc_stat_s osc_stat,
  input wire logic powerup_done,
  input wire logic sleep_enter,
  input wire logic wake_up,
  input wire logic ext_clk,
  input wire logic int_clk,
  input wire logic low_clk,
  output logic [1:0] clk_source,
  output logic [3:0] int_osc_freq_select,
  output logic pll_enable,
  output logic osc_fail_irq
);
  import tsc_pkg::*;

  localparam int OW = $clog2(STARTUP_COUNT + 1);
  localparam int DW = $clog2(SAMPLE_DIV);
  localparam int HALF = SAMPLE_DIV / 2;

  typedef struct packed {
    tsc_state_e st;
    logic [OW-1:0] su_cnt;
    logic [DW-1:0] div_cnt;
    logic [2:0] ext_s;
    logic [2:0] int_s;
    logic [2:0] low_s;
    logic latch;
    logic [1:0] fail_s;
    logic fail_safe;
    logic tmr_done;
    logic osc_fail_flag;
    logic osc_fail_irq_enable;
    logic sw_pll_enable;
    logic [3:0] freq;
    logic [1:0] sys_clock_select;
    logic started;
    logic aw_hit;
    logic [3:0] aw_addr;
    logic w_hit;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } tsc_state_s;

  tsc_state_s q, d;
  logic crystal, two_speed, ext_fall, int_fall, low_rise, sample_rise;
  logic sample_clk, fail_now, wr_go, scs_change;
  logic miss_now, watch_ext, restart_xtal, direct_ext;
  logic [7:0] ctrl_rd, stat_rd, fail_rd, wbyte;

  // edge detectors read only the second and third synchroniser stages
  assign ext_fall = q.ext_s[2] & ~q.ext_s[1];
  assign int_fall = q.int_s[2] & ~q.int_s[1];
  assign low_rise = q.low_s[1] & ~q.low_s[2];
  assign sample_clk = q.div_cnt[DW-1]; // see R10
  assign sample_rise = low_rise && (q.div_cnt == DW'(HALF - 1));

  assign crystal = (cfg.osc_mode_config == `TSC_MODE_LOWPWR) ||
                   (cfg.osc_mode_config == `TSC_MODE_STD) ||
                   (cfg.osc_mode_config == `TSC_MODE_FAST); // see R02
  // the monitor forces two-speed start-up on as well
  assign two_speed = (cfg.two_speed_config_enable | cfg.fail_monitor_enable)
                     && q.sys_clock_select == `TSC_SCS_CFG
                     && crystal; // see R05 see R09
  assign fail_now = q.fail_s[1];
  assign wr_go = q.aw_hit && q.w_hit && !q.bvalid;
  assign wbyte = q.w_data[7:0];
  assign scs_change = wr_go && q.aw_addr == `TSC_OFF_CTRL && q.w_strb[0] &&
                      wbyte[1:0] != q.sys_clock_select;
  assign restart_xtal = wbyte[1:0] == `TSC_SCS_CFG && crystal;
  // with no start-up timer the external clock is taken at once, see R17
  assign direct_ext = !two_speed && q.sys_clock_select == `TSC_SCS_CFG;

  // a sample edge that finds the latch still clear is a missed clock
  assign miss_now = sample_rise && !q.latch && !ext_fall; // see R11
  // watched only after hand-over; a parked crystal must not raise the flag
  assign watch_ext = cfg.fail_monitor_enable && q.st == TSC_ST_EXT &&
                     q.sys_clock_select == `TSC_SCS_CFG; // see R09

  always_comb begin
    ctrl_rd = 8'h00;
    ctrl_rd[`TSC_CTRL_PLL_BIT] = q.sw_pll_enable;
    ctrl_rd[`TSC_CTRL_FREQ_HI:`TSC_CTRL_FREQ_LO] = q.freq;
    ctrl_rd[1:0] = q.sys_clock_select;
    stat_rd = 8'h00;
    stat_rd[`TSC_STAT_SOSC_BIT] = osc_stat.sec_osc_enable ?
      osc_stat.sec_osc_raw_ready : 1'b1; // see R21
    stat_rd[`TSC_STAT_PLL_RDY_BIT] = osc_stat.pll_ready_status; // see R22
    stat_rd[`TSC_STAT_TMR_DONE_BIT] = q.tmr_done; // see R08
    stat_rd[`TSC_STAT_HFR_BIT] = osc_stat.high_osc_ready;
    stat_rd[`TSC_STAT_HFL_BIT] = osc_stat.high_osc_locked;
    stat_rd[`TSC_STAT_MFR_BIT] = osc_stat.mid_osc_ready;
    stat_rd[`TSC_STAT_LFR_BIT] = osc_stat.low_osc_ready;
    stat_rd[`TSC_STAT_HFS_BIT] = osc_stat.high_osc_stable;
    fail_rd = 8'h00;
    fail_rd[`TSC_FAIL_FLAG_BIT] = q.osc_fail_flag;
    fail_rd[`TSC_FAIL_IE_BIT] = q.osc_fail_irq_enable;
  end

  always_comb begin
    d = q;
    d.ext_s = {q.ext_s[1:0], ext_clk};
    d.int_s = {q.int_s[1:0], int_clk};
    d.low_s = {q.low_s[1:0], low_clk};

    if (low_rise) begin
      d.div_cnt = q.div_cnt + DW'(1); // see R10
    end

    // latch: external fall sets it, sample rise clears and checks it
    if (ext_fall) begin
      d.latch = 1'b1; // see R11
    end else if (sample_rise) begin
      d.latch = 1'b0; // see R11
    end
    // two flops between detector and the switch/flag, see R25
    d.fail_s = {q.fail_s[0], miss_now && watch_ext};

    // start-up sequencer
    case (q.st)
      TSC_ST_IDLE: begin
        if (!q.started && powerup_done) begin
          d.started = 1'b1; // see R06
          d.su_cnt = '0;
          d.st = two_speed ? TSC_ST_COUNT : TSC_ST_EXT; // see R17
          d.tmr_done = direct_ext;
        end
      end
      TSC_ST_COUNT: begin
        // counts falls of the synchronised crystal clock
        if (ext_fall) begin
          d.su_cnt = q.su_cnt + OW'(1); // see R01
        end
        if (q.su_cnt == OW'(STARTUP_COUNT)) begin
          d.st = TSC_ST_WAIT_INT; // see R07
        end
      end
      TSC_ST_WAIT_INT: begin
        if (int_fall) begin
          d.tmr_done = 1'b1; // see R03 see R07
          d.st = TSC_ST_HOLD;
        end
      end
      TSC_ST_HOLD: begin
        // clock held low here; the external fall lets it resume cleanly
        if (ext_fall) begin
          d.st = TSC_ST_EXT; // see R07
          d.fail_safe = 1'b0; // see R15
        end
      end
      TSC_ST_EXT: begin
        if (fail_now && q.sys_clock_select == `TSC_SCS_CFG) begin
          d.fail_safe = 1'b1; // see R12 see R13
          d.tmr_done = 1'b0;
        end
      end
      default: begin
        d.st = TSC_ST_IDLE;
      end
    endcase

    if (wake_up) begin
      d.su_cnt = '0;
      d.st = two_speed ? TSC_ST_COUNT : TSC_ST_EXT; // see R06 see R17
      d.tmr_done = direct_ext;
    end

    if (sleep_enter) begin
      d.st = TSC_ST_IDLE; // see R04
      d.started = 1'b1;
      d.tmr_done = 1'b0;
      d.fail_safe = 1'b0; // see R14
    end

    // register writes
    if (axi_req.awvalid && !q.aw_hit) begin
      d.aw_hit = 1'b1;
      d.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && !q.w_hit) begin
      d.w_hit = 1'b1;
      d.w_data = axi_req.wdata;
      d.w_strb = axi_req.wstrb;
    end
    if (wr_go) begin
      d.bvalid = 1'b1;
      d.bresp = `TSC_RESP_OKAY;
      case (q.aw_addr)
        `TSC_OFF_CTRL: begin
          if (q.w_strb[0]) begin
            d.sw_pll_enable = wbyte[`TSC_CTRL_PLL_BIT];
            d.freq = wbyte[`TSC_CTRL_FREQ_HI:`TSC_CTRL_FREQ_LO];
            d.sys_clock_select = wbyte[1:0];
          end
        end
        `TSC_OFF_FAIL: begin
          if (q.w_strb[0]) begin
            d.osc_fail_irq_enable = wbyte[`TSC_FAIL_IE_BIT];
            d.osc_fail_flag = q.osc_fail_flag & wbyte[`TSC_FAIL_FLAG_BIT];
          end
        end
        `TSC_OFF_STAT: begin
          // status is read only; the write is accepted and dropped
          d.bresp = `TSC_RESP_OKAY;
        end
        default: begin
          d.bresp = `TSC_RESP_SLVERR;
        end
      endcase
    end

    if (scs_change) begin
      // fail-safe held until the restarted timer lands on external clock
      d.su_cnt = '0;
      d.tmr_done = 1'b0;
      d.st = restart_xtal ? TSC_ST_COUNT : TSC_ST_EXT; // see R15
      if (!restart_xtal) begin
        d.fail_safe = 1'b0; // see R14
      end
    end

    // hardware set wins over a software clear in the same cycle
    if (fail_now) begin
      d.osc_fail_flag = 1'b1; // see R12 see R16
    end

    // response accepted: both capture slots open again
    if (q.bvalid && axi_req.bready) begin
      d.bvalid = 1'b0;
      d.aw_hit = 1'b0;
      d.w_hit = 1'b0;
    end

    // bits 31:8 of every register read as zero
    if (axi_req.arvalid && !q.rvalid) begin
      d.rvalid = 1'b1;
      d.rresp = `TSC_RESP_OKAY;
      case (axi_req.araddr)
        `TSC_OFF_CTRL: begin
          d.rdata = {24'h000000, ctrl_rd};
        end
        `TSC_OFF_STAT: begin
          d.rdata = {24'h000000, stat_rd};
        end
        `TSC_OFF_FAIL: begin
          d.rdata = {24'h000000, fail_rd};
        end
        default: begin
          d.rdata = 32'h00000000;
          d.rresp = `TSC_RESP_SLVERR;
        end
      endcase
    end else if (q.rvalid && axi_req.rready) begin
      d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      q <= '0;
      q.st <= TSC_ST_IDLE;
      q.freq <= 4'(`TSC_CTRL_RESET >> `TSC_CTRL_FREQ_LO); // see R19
      q.tmr_done <= 1'b0; // see R08
      q.osc_fail_flag <= 1'b0;
      q.sys_clock_select <= `TSC_SCS_CFG; // see R23
      q.fail_safe <= 1'b0; // see R14
    end else begin
      q <= d;
    end
  end

  always_comb begin
    axi_rsp.awready = !q.aw_hit;
    axi_rsp.wready = !q.w_hit;
    axi_rsp.bvalid = q.bvalid;
    axi_rsp.bresp = q.bresp;
    axi_rsp.arready = !q.rvalid;
    axi_rsp.rvalid = q.rvalid;
    axi_rsp.rdata = q.rdata;
    axi_rsp.rresp = q.rresp;
  end

  // automatic switches steer clk_source only, never the select, see R24
  always_comb begin
    if (q.sys_clock_select[1]) begin
      clk_source = TSC_SRC_INT; // see R20
    end else if (q.sys_clock_select == `TSC_SCS_SEC) begin
      clk_source = q.fail_safe ? TSC_SRC_INT : TSC_SRC_SEC; // see R20
    end else if (q.st == TSC_ST_EXT && !q.fail_safe &&
                 cfg.osc_mode_config != `TSC_MODE_INTERNAL) begin
      clk_source = TSC_SRC_EXT; // see R08
    end else begin
      clk_source = TSC_SRC_INT; // see R12
    end
  end

  assign int_osc_freq_select = q.freq;
  assign pll_enable = cfg.cfg_pll_enable | q.sw_pll_enable; // see R18
  assign osc_fail_irq = q.osc_fail_flag & q.osc_fail_irq_enable; // see R12
endmodule : tsc_clock_ctrl
`default_nettype wire

// *** tsc_xtal_model.sv ***
// crystal model on the far side of the start-up and fail-safe logic
`timescale 1ns/10ps
`default_nettype none
module tsc_xtal_model #(
  parameter int HALF_NS = 20
) (
  input wire logic run,
  output logic ext_clk
);
  initial ext_clk = 1'b0;
  // a dead crystal leaves the pin low, so no stray edge can hide a failure
  always begin
    #(HALF_NS);
    ext_clk = run ? ~ext_clk : 1'b0;
  end
endmodule : tsc_xtal_model
`default_nettype wire

// *** tsc_clock_ctrl_monitor.sv ***
// assertions on the ports of the clock control block
`timescale 1ns/10ps
`default_nettype none
module tsc_clock_ctrl_monitor #(
  parameter int STARTUP_COUNT = 1024,
  parameter int SAMPLE_DIV = 64
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire tsc_pkg::tsc_axi_req_s axi_req,
  input wire tsc_pkg::tsc_axi_rsp_s axi_rsp,
  input wire tsc_pkg::tsc_cfg_s cfg,
  input wire logic [1:0] clk_source,
  input wire logic [3:0] int_osc_freq_select,
  input wire logic pll_enable
);
  import tsc_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  chk_freq_reset: assert property (
    $fell(sys_rst) |-> int_osc_freq_select == 4'h7)
    else $error("freq select wrong after reset");
  chk_src_reset: assert property (
    $fell(sys_rst) |-> clk_source == 2'h0)
    else $error("clock source not internal after reset");
  chk_src_legal: assert property (
    clk_source != 2'h3)
    else $error("clock source code illegal");
  chk_pll_force: assert property (
    cfg.cfg_pll_enable |-> ##[0:2] pll_enable)
    else $error("pll not forced on");
  chk_read_answer: assert property (
    axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
    else $error("read answer late");
  chk_read_hold: assert property (
    axi_rsp.rvalid && !axi_req.rready |=>
      axi_rsp.rvalid && $stable(axi_rsp.rdata))
    else $error("read data dropped");
  chk_write_hold: assert property (
    axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid)
    else $error("write answer dropped");
  chk_unmapped_read: assert property (
    axi_req.arvalid && axi_rsp.arready && axi_req.araddr[3:2] == 2'h3
      |=> axi_rsp.rresp == 2'h2 && axi_rsp.rdata == 32'h0)
    else $error("unmapped read not refused");
endmodule : tsc_clock_ctrl_monitor
`default_nettype wire

// *** tsc_clock_ctrl_bench.sv ***
// self-checking bench for the clock control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, a) \
  begin \
    n_tests++; \
    if ((a) !== (e)) begin \
      err_total++; \
      $display("[FAIL] %s exp %0h got %0h", nm, e, a); \
    end \
  end
module tsc_clock_ctrl_bench;
  import tsc_pkg::*;
  localparam int SU_N = 8;
  localparam int SMP_N = 4;
  logic clk_sys, sys_rst, powerup_done, sleep_enter, wake_up, run;
  logic ext_clk, int_clk, low_clk, pll_enable, osc_fail_irq;
  logic [1:0] clk_source;
  logic [3:0] freq;
  logic [31:0] d;
  logic [1:0] r;
  tsc_axi_req_s rq;
  tsc_axi_rsp_s rs;
  tsc_cfg_s cfg;
  tsc_osc_stat_s osc_stat;
  int err_total, n_tests;
  tsc_clock_ctrl #(
    .STARTUP_COUNT(SU_N), .SAMPLE_DIV(SMP_N)
  ) tsc_clock_ctrl_inst (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .axi_req(rq), .axi_rsp(rs),
    .cfg(cfg), .osc_stat(osc_stat), .powerup_done(powerup_done),
    .sleep_enter(sleep_enter), .wake_up(wake_up), .ext_clk(ext_clk),
    .int_clk(int_clk), .low_clk(low_clk), .clk_source(clk_source),
    .int_osc_freq_select(freq), .pll_enable(pll_enable),
    .osc_fail_irq(osc_fail_irq)
  );
  tsc_xtal_model tsc_xtal_model_inst (.run(run), .ext_clk(ext_clk));
  task automatic wrap_up;
    if (err_total == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up
  task automatic tmo(input int n);
    if (n >= 600) begin
      err_total++;
      wrap_up();
    end
  endtask : tmo
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    int n;
    logic ta, tw, tb;
    n = 0;
    tb = 1'b0;
    rq.awvalid <= 1'b1;
    rq.awaddr <= a;
    rq.wvalid <= 1'b1;
    rq.wdata <= {24'h0, v};
    rq.wstrb <= 4'h1;
    rq.bready <= 1'b1;
    while (!tb && n < 600) begin
      @(negedge clk_sys);
      ta = rq.awvalid & rs.awready;
      tw = rq.wvalid & rs.wready;
      tb = rs.bvalid;
      @(posedge clk_sys);
      if (ta) rq.awvalid <= 1'b0;
      if (tw) rq.wvalid <= 1'b0;
      n++;
    end
    tmo(n);
    rq.bready <= 1'b0;
    @(posedge clk_sys);
  endtask : wr
  task automatic rd(input logic [3:0] a);
    int n;
    logic ta, tv;
    n = 0;
    tv = 1'b0;
    rq.arvalid <= 1'b1;
    rq.araddr <= a;
    rq.rready <= 1'b1;
    while (!tv && n < 600) begin
      @(negedge clk_sys);
      ta = rq.arvalid & rs.arready;
      tv = rs.rvalid;
      d = rs.rdata;
      r = rs.rresp;
      @(posedge clk_sys);
      if (ta) rq.arvalid <= 1'b0;
      n++;
    end
    tmo(n);
    rq.rready <= 1'b0;
    @(posedge clk_sys);
  endtask : rd
  task automatic wait_src(input logic [1:0] v);
    int n;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (clk_source !== v && n < 600);
    tmo(n);
    @(posedge clk_sys);
  endtask : wait_src
  task automatic src_is(input logic [1:0] v);
    @(negedge clk_sys);
    `CHK("clk_source", v, clk_source)
    @(posedge clk_sys);
  endtask : src_is
  task automatic nap(input logic w);
    sleep_enter <= 1'b1;
    @(posedge clk_sys);
    sleep_enter <= 1'b0;
    repeat (4) @(posedge clk_sys);
    wake_up <= w;
    @(posedge clk_sys);
    wake_up <= 1'b0;
  endtask : nap
  task automatic t_regs;
    rd(4'h0);
    `CHK("ctrl", 32'h38, d)
    rd(4'h4);
    `CHK("tmr_done", 1'b0, d[5])
    `CHK("sec_ready", 1'b1, d[7])
    rd(4'hc);
    `CHK("resp", 2'h2, r)
  endtask : t_regs
  task automatic t_boot;
    powerup_done <= 1'b1;
    repeat (SU_N * 2) @(posedge clk_sys);
    src_is(2'h0);
    wait_src(2'h1);
    rd(4'h4);
    `CHK("tmr_done", 1'b1, d[5])
  endtask : t_boot
  task automatic t_fail;
    run <= 1'b0;
    wait_src(2'h0);
    `CHK("irq", 1'b0, osc_fail_irq)
    wr(4'h8, 8'h02);
    repeat (SMP_N * 20) @(posedge clk_sys);
    rd(4'h8);
    `CHK("flag", 1'b1, d[0])
    `CHK("irq", 1'b1, osc_fail_irq)
    rd(4'h0);
    `CHK("ctrl", 32'h38, d)
  endtask : t_fail
  task automatic t_back;
    run <= 1'b1;
    repeat (SMP_N * 20) @(posedge clk_sys);
    src_is(2'h0);
    wr(4'h8, 8'h00);
    wr(4'h0, 8'h39);
    wait_src(2'h2);
    wr(4'h0, 8'h3a);
    wait_src(2'h0);
    wr(4'h0, 8'h38);
    src_is(2'h0);
    wait_src(2'h1);
    rd(4'h8);
    `CHK("flag", 1'b0, d[0])
  endtask : t_back
  task automatic t_sleep;
    nap(1'b1);
    src_is(2'h0);
    nap(1'b0);
    repeat (SU_N * 8) @(posedge clk_sys);
    rd(4'h4);
    `CHK("tmr_done", 1'b0, d[5])
    nap(1'b1);
    wait_src(2'h1);
  endtask : t_sleep
  task automatic t_ext;
    cfg.osc_mode_config <= 3'h3;
    nap(1'b1);
    repeat (SU_N) @(posedge clk_sys);
    src_is(2'h1);
    run <= 1'b0;
    wait_src(2'h0);
  endtask : t_ext
  task automatic t_pll;
    wr(4'h0, 8'hb8);
    `CHK("pll", 1'b1, pll_enable)
    wr(4'h0, 8'h38);
    `CHK("pll", 1'b0, pll_enable)
    cfg.cfg_pll_enable <= 1'b1;
    repeat (2) @(posedge clk_sys);
    `CHK("pll", 1'b1, pll_enable)
  endtask : t_pll
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    int_clk = 1'b0;
    forever #15 int_clk = ~int_clk;
  end
  initial begin
    low_clk = 1'b0;
    forever #50 low_clk = ~low_clk;
  end
  initial begin
    #500000;
    err_total++;
    wrap_up();
  end
  initial begin
    err_total = 0;
    n_tests = 0;
    rq = '0;
    cfg = 6'h0e;
    osc_stat = 8'h00;
    {powerup_done, sleep_enter, wake_up} = 3'h0;
    run = 1'b1;
    sys_rst = 1'b1;
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    t_regs();
    t_boot();
    t_fail();
    t_back();
    t_sleep();
    t_ext();
    t_pll();
    wrap_up();
  end
endmodule : tsc_clock_ctrl_bench
bind tsc_clock_ctrl tsc_clock_ctrl_monitor #(
  .STARTUP_COUNT(STARTUP_COUNT), .SAMPLE_DIV(SAMPLE_DIV)
) tsc_clock_ctrl_monitor_inst (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .axi_req(axi_req),
  .axi_rsp(axi_rsp), .cfg(cfg), .clk_source(clk_source),
  .int_osc_freq_select(int_osc_freq_select), .pll_enable(pll_enable)
);
`default_nettype wire
